// ===== core/ttp_pkg.sv
// Shared constants, field layouts, types and tone tables of the tone transceiver host port.
package ttp_pkg;

    // Host access decode values.
    localparam logic RS_DATA  = 1'b0;
    localparam logic RS_CTRL  = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ  = 1'b1;

    // Register indices on the select line.
    localparam logic [0:0] TRANSMIT_CODE_OFS = 1'h0;
    localparam logic [0:0] RECEIVE_CODE_OFS  = 1'h0;
    localparam logic [0:0] CONTROL_A_OFS     = 1'h1;
    localparam logic [0:0] CONTROL_B_OFS     = 1'h1;
    localparam logic [0:0] STATUS_OFS        = 1'h1;

    // Reset values.
    localparam logic [3:0] CONTROL_A_RST     = 4'h0;
    localparam logic [3:0] CONTROL_B_RST     = 4'h0;
    localparam logic [3:0] TRANSMIT_CODE_RST = 4'h0;
    localparam logic [3:0] RECEIVE_CODE_RST  = 4'h0;

    // Timing.
    localparam int unsigned CORE_HZ      = 10_000_000;
    localparam int unsigned BURST_MS     = 51;
    localparam int unsigned BURST_CYCLES = BURST_MS * (CORE_HZ / 1000);
    localparam int unsigned TONE_SEGS    = 32;

    // Control register A, bit b3 down to b0.
    typedef struct packed {
        logic second_control_select;
        logic irq_enable;
        logic call_progress_mode_select;
        logic tone_output_enable;
    } ttp_cra_t;

    // Control register B, bit b3 down to b0.
    typedef struct packed {
        logic column_select;
        logic single_tone;
        logic test_mode;
        logic burst_disable;
    } ttp_crb_t;

    // Status register, bit b3 down to b0.
    typedef struct packed {
        logic steer_absent;
        logic rx_full;
        logic tx_ready;
        logic irq;
    } ttp_status_t;

    // Host bus pins.
    typedef struct packed {
        logic       cs_n;
        logic       strobe;
        logic       register_select_line;
        logic       read_not_write;
        logic [3:0] data;
    } ttp_bus_t;

    // Digital outputs of the analog receive path.
    typedef struct packed {
        logic       steer;
        logic       cp_detect;
        logic [3:0] code;
    } ttp_rx_t;

    typedef enum logic [2:0] {
        BST_IDLE  = 3'b001,
        BST_TONE  = 3'b010,
        BST_PAUSE = 3'b100
    } ttp_burst_t;

    // Reference ticks per segment; 32 segments make one tone period.
    localparam logic [7:0] ROW_DIV [4] = '{8'ha0, 8'h92, 8'h84, 8'h76};
    localparam logic [7:0] COL_DIV [4] = '{8'h5c, 8'h54, 8'h4c, 8'h44};

    // Maps a 4-bit key code to {row index, column index}.
    function automatic logic [3:0] ttp_key_map(input logic [3:0] code);
        logic [3:0] rc;
        unique case (code)
            4'h1: rc = 4'h0;
            4'h2: rc = 4'h1;
            4'h3: rc = 4'h2;
            4'h4: rc = 4'h4;
            4'h5: rc = 4'h5;
            4'h6: rc = 4'h6;
            4'h7: rc = 4'h8;
            4'h8: rc = 4'h9;
            4'h9: rc = 4'ha;
            4'ha: rc = 4'hd;
            4'hb: rc = 4'hc;
            4'hc: rc = 4'he;
            4'hd: rc = 4'h3;
            4'he: rc = 4'h7;
            4'hf: rc = 4'hb;
            4'h0: rc = 4'hf;
        endcase
        return rc;
    endfunction

endpackage

// ===== core/ttp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module ttp_sync #(
    parameter int W = 1
) (
    // Clock and control
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_q <= '0;
            q      <= '0;
        end else if (clk_en) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ===== core/ttp_tone_div.sv
// Programmable tone divider: counts reference ticks into 32 segments per period.
`timescale 1ns/1ns
module ttp_tone_div
    import ttp_pkg::*;
(
    // Clock and control
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    // Tone control
    input  wire logic       ref_tick,
    input  wire logic       run,
    input  wire logic [7:0] divisor,
    // Segment index for the sine table
    output logic      [4:0] seg_q
);
    logic [7:0] tick_cnt_q;
    wire        seg_done = ref_tick && (tick_cnt_q == divisor - 8'h01);

    always_ff @(posedge core_clk) begin
        if (srst || (clk_en && !run)) begin
            tick_cnt_q <= 8'h00;
            seg_q      <= 5'h00;
        end else if (clk_en && ref_tick) begin
            tick_cnt_q <= seg_done ? 8'h00 : tick_cnt_q + 8'h01;
            if (seg_done) begin
                seg_q <= seg_q + 5'h01;
            end
        end
    end
endmodule

// ===== core/ttp_host_port.sv
// Host register port, burst timer and tone control of the tone transceiver.
//
// Overview of operation
// R1 - Select and read/write lines pick transmit, receive, control or status register.
// R2 - Receive register keeps last valid decoded code; host cannot write it.
// R3 - Transmit register is write only; its code picks the generated tone pair.
// R4 - Control A b3 sends the next control write to B, then back to A.
// R5 - Host initialises control and status registers after power-up.
// R6 - Interrupt pin is open drain: pulls low or releases.
// R7 - Control A b0 enables tone output, with or without burst timing.
// R8 - Control A b1 picks tone mode (0) or call-progress mode (1).
// R9 - Call-progress mode with interrupt enable shows detected tone on the pin.
// R10 - Call-progress mode doubles burst and pause to about 102 ms.
// R11 - Call-progress mode stops decoding; receive register stays unchanged.
// R12 - Tone mode with interrupt enable pulls pin on valid tone or ready.
// R13 - Row and column tones come from reference divisions per key.
// R14 - All tone timing derives from the 3.579545 MHz reference clock; burst and pause lengths here count core_clk cycles (CORE_HZ).
// R15 - Control B b0 low enables burst: burst, equal pause, then ready.
// R16 - Tone mode burst and pause each last 51 ms.
// R17 - Status read clears interrupt, ready and full flags and releases pin.
// R18 - Redirected control write leaves control A untouched and ends redirection.
// R19 - All registers are four bits on data lines b3 to b0.
`timescale 1ns/1ns
module ttp_host_port
    import ttp_pkg::*;
#(
    parameter int unsigned P_BURST_CYCLES = BURST_CYCLES
) (
    // Clock and control
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    // Host bus pins
    input  wire ttp_bus_t   host_bus,
    output logic      [3:0] host_data_out,
    output logic            host_data_oe,
    // Receive path and reference clock pins
    input  wire ttp_rx_t    rx_pins,
    input  wire logic       clock_input_pin,
    // Interrupt or call-progress pin
    output logic            interrupt_or_tone_pin_out,
    output logic            interrupt_or_tone_pin_oe,
    // Tone generator
    output logic      [4:0] row_seg,
    output logic      [4:0] col_seg,
    output logic            row_on,
    output logic            col_on
);
    localparam int CW = 21;

    ttp_bus_t     bus_s;
    ttp_rx_t      rx_s;
    logic         ref_s;
    logic         strobe_q;
    logic         steer_q;
    logic         ref_q;
    ttp_cra_t     cra_q;
    ttp_crb_t     crb_q;
    logic         redirect_q;
    logic [3:0]   tx_code_q;
    logic [3:0]   rx_code_q;
    ttp_status_t  st_q;
    ttp_burst_t   bst_q;
    ttp_burst_t   bst_d;
    logic [CW-1:0] bcnt_q;
    logic [CW-1:0] bcnt_d;

    ttp_sync #(.W($bits(ttp_bus_t) + $bits(ttp_rx_t) + 1)) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .d        ({host_bus, rx_pins, clock_input_pin}),
        .q        ({bus_s, rx_s, ref_s})
    );

    // Access decode on the rising strobe edge.
    wire access = bus_s.strobe && !strobe_q && !bus_s.cs_n;
    wire wr_tx  = access && bus_s.register_select_line == RS_DATA
                  && bus_s.read_not_write == RW_WRITE;                         // see R1
    wire rd_rx  = access && bus_s.register_select_line == RS_DATA
                  && bus_s.read_not_write == RW_READ;                          // see R1
    wire wr_ctl = access && bus_s.register_select_line == RS_CTRL
                  && bus_s.read_not_write == RW_WRITE;                         // see R1
    wire rd_st  = access && bus_s.register_select_line == RS_CTRL
                  && bus_s.read_not_write == RW_READ;                          // see R1
    wire rd_hold = bus_s.strobe && !bus_s.cs_n && bus_s.read_not_write == RW_READ;

    wire cp_mode  = cra_q.call_progress_mode_select;                           // see R8
    wire burst_on = !crb_q.burst_disable;                                      // see R15
    wire ref_tick = ref_s && !ref_q;                                           // see R14
    wire rx_evt   = rx_s.steer && !steer_q && !cp_mode;                        // see R11
    wire tx_evt   = bst_q == BST_PAUSE && bcnt_q == '0;                        // see R15

    // Burst and pause length, doubled in call-progress mode.
    wire [CW-1:0] blen = cp_mode ? CW'(2 * P_BURST_CYCLES - 1)                 // see R10
                                 : CW'(P_BURST_CYCLES - 1);                    // see R16

    wire [3:0] key      = ttp_key_map(tx_code_q);                              // see R3
    wire       tone_run = cra_q.tone_output_enable
                          && (!burst_on || bst_q == BST_TONE);                 // see R7

    wire [3:0] rd_data = bus_s.register_select_line == RS_CTRL ? st_q : rx_code_q;

    // Pin pulls low: call-progress tone, test steering, or pending interrupt.
    wire pin_pull = cp_mode ? (cra_q.irq_enable && rx_s.cp_detect)            // see R9
                  : crb_q.test_mode ? rx_s.steer
                  : (cra_q.irq_enable && st_q.irq && !rd_st);                  // see R12

    always_comb begin
        bst_d  = bst_q;
        bcnt_d = bcnt_q;
        if (wr_tx && burst_on) begin
            bst_d  = BST_TONE;                                                 // see R15
            bcnt_d = blen;
        end else begin
            unique case (bst_q)
                BST_IDLE: begin
                    bcnt_d = '0;
                end
                BST_TONE: begin
                    if (bcnt_q == '0) begin
                        bst_d  = BST_PAUSE;
                        bcnt_d = blen;
                    end else begin
                        bcnt_d = bcnt_q - CW'(1);
                    end
                end
                BST_PAUSE: begin
                    if (bcnt_q == '0) begin
                        bst_d = BST_IDLE;
                    end else begin
                        bcnt_d = bcnt_q - CW'(1);
                    end
                end
                default: begin
                    bst_d  = BST_IDLE;
                    bcnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            strobe_q <= 1'b0;
            steer_q  <= 1'b0;
            ref_q    <= 1'b0;
            bst_q    <= BST_IDLE;
            bcnt_q   <= '0;
        end else if (clk_en) begin
            strobe_q <= bus_s.strobe;
            steer_q  <= rx_s.steer;
            ref_q    <= ref_s;
            bst_q    <= bst_d;
            bcnt_q   <= bcnt_d;
        end
    end

    // Control registers share one address.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cra_q      <= CONTROL_A_RST;
            crb_q      <= CONTROL_B_RST;
            redirect_q <= 1'b0;
        end else if (clk_en && wr_ctl) begin
            if (redirect_q) begin
                crb_q      <= bus_s.data;                                      // see R4
                redirect_q <= 1'b0;                                            // see R18
            end else begin
                cra_q      <= bus_s.data;                                      // see R19
                redirect_q <= bus_s.data[3];                                   // see R4
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_code_q <= TRANSMIT_CODE_RST;
            rx_code_q <= RECEIVE_CODE_RST;
        end else if (clk_en) begin
            if (wr_tx) begin
                tx_code_q <= bus_s.data;                                       // see R3
            end
            if (rx_evt) begin
                rx_code_q <= rx_s.code;                                        // see R2
            end
        end
    end

    // Status flags: a set in the same cycle as a status read wins.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q.irq          <= rx_evt || tx_evt || (st_q.irq && !rd_st);    // see R17
            st_q.tx_ready     <= tx_evt || (st_q.tx_ready && !rd_st && burst_on);
            st_q.rx_full      <= rx_evt || (st_q.rx_full && !rd_st);           // see R17
            st_q.steer_absent <= !rx_s.steer;
        end
    end

    // Registered pin outputs.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            host_data_out             <= 4'h0;
            host_data_oe              <= 1'b0;
            interrupt_or_tone_pin_out <= 1'b0;
            interrupt_or_tone_pin_oe  <= 1'b0;
            row_on                    <= 1'b0;
            col_on                    <= 1'b0;
        end else if (clk_en) begin
            if (rd_rx || rd_st) begin
                host_data_out <= rd_data;
            end
            host_data_oe              <= rd_hold;
            interrupt_or_tone_pin_out <= 1'b0;                                 // see R6
            interrupt_or_tone_pin_oe  <= pin_pull;                             // see R6
            row_on <= tone_run && !(crb_q.single_tone && crb_q.column_select);
            col_on <= tone_run && !(crb_q.single_tone && !crb_q.column_select);
        end
    end

    ttp_tone_div u_row (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .ref_tick (ref_tick),
        .run      (tone_run),
        .divisor  (ROW_DIV[key[3:2]]),                                         // see R13
        .seg_q    (row_seg)
    );

    ttp_tone_div u_col (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .ref_tick (ref_tick),
        .run      (tone_run),
        .divisor  (COL_DIV[key[1:0]]),                                         // see R13
        .seg_q    (col_seg)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst || !clk_en);

    sequence s_redirect_armed;
        wr_ctl && !redirect_q && bus_s.data[3];
    endsequence

    sequence s_redirected_write;
        wr_ctl && redirect_q;
    endsequence

    sequence s_status_read;
        rd_st && !rx_evt && !tx_evt;
    endsequence

    chk_rx_hold_cp: assert property (cp_mode |=> $stable(rx_code_q))          // see R11
        else $error("receive code changed in call-progress mode");
    chk_rx_latch: assert property (rx_evt |=> rx_code_q == $past(rx_s.code))  // see R2
        else $error("valid tone code not latched");
    chk_rx_no_write: assert property (wr_tx && !rx_evt |=> $stable(rx_code_q)) // see R2
        else $error("transmit write altered receive code");
    chk_redirect_arm: assert property (s_redirect_armed |=> redirect_q)       // see R4
        else $error("control b redirection not armed");
    chk_cra_untouched: assert property (s_redirected_write |=>                // see R18
        $stable(cra_q) && !redirect_q)
        else $error("redirected write touched control a");
    chk_pin_low_only: assert property (interrupt_or_tone_pin_out == 1'b0)     // see R6
        else $error("interrupt pin driven high");
    chk_status_clear: assert property (s_status_read |=>                      // see R17
        !st_q.irq && !st_q.rx_full && !st_q.tx_ready ##1 !interrupt_or_tone_pin_oe
        || cp_mode || crb_q.test_mode)
        else $error("status read did not clear flags");
    chk_ready_irq: assert property (tx_evt && !cp_mode && !crb_q.test_mode    // see R12
        && cra_q.irq_enable |=> rd_st or ##1 interrupt_or_tone_pin_oe)
        else $error("ready did not pull interrupt pin");
    chk_burst_pause: assert property ($rose(bst_q == BST_PAUSE) |->           // see R15
        bcnt_q == $past(blen) && !tone_run)
        else $error("pause start wrong");
    chk_tone_free: assert property (!burst_on && cra_q.tone_output_enable     // see R7
        |-> tone_run)
        else $error("tone not running in non-burst mode");

    // Read data leaves as it stood in the cycle of the access.
    chk_status_data: assert property (rd_st |=> host_data_out == $past(st_q)) // see R17
        else $error("status read returned wrong word");
    chk_receive_data: assert property (rd_rx |=> host_data_out == $past(rx_code_q)) // see R2
        else $error("receive read returned wrong code");
    chk_tx_latch: assert property (wr_tx |=> tx_code_q == $past(bus_s.data))  // see R3
        else $error("transmit code not latched");
    chk_cra_write: assert property (wr_ctl && !redirect_q |=>                 // see R4
        cra_q == $past(bus_s.data))
        else $error("control a write not taken");
    chk_full_irq: assert property (rx_evt |=> st_q.rx_full && st_q.irq)       // see R12
        else $error("valid tone did not raise full and interrupt");
    chk_ready_nonburst: assert property (!burst_on && !tx_evt |=> !st_q.tx_ready) // see R15
        else $error("ready flag kept in non-burst mode");

    chk_cp_pin: assert property (cp_mode |=>                                  // see R9
        interrupt_or_tone_pin_oe == ($past(cra_q.irq_enable) && $past(rx_s.cp_detect)))
        else $error("call-progress tone not shown on pin");
    chk_test_pin: assert property (!cp_mode && crb_q.test_mode |=>            // see R6
        interrupt_or_tone_pin_oe == $past(rx_s.steer))
        else $error("test mode pin does not follow steering");
endmodule

// ===== testbench/ttp_host_model.sv
// Host processor model that drives the register bus pins of the port.
`timescale 1ns/1ns
module ttp_host_model
    import ttp_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Bus pins
    output ttp_bus_t  host_bus,
    input  wire logic host_data_oe
);
    // Deselected with strobe low; data lines float to a pattern.
    initial begin
        host_bus = 8'h95;
    end

    // Pins change just after an edge and stand until the port has taken them.
    task automatic access(input logic rs, input logic rw, input logic [3:0] d);
        int n;
        n = 0;
        repeat (4) @(posedge core_clk);
        #1;
        host_bus = {1'b0, 1'b1, rs, rw, rw ? ~host_bus.data : d};
        if (rw) begin
            while (host_data_oe !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                n++;
            end
            if (n == 20) begin
                tb.failures++;
                $display("ERROR %0t no read answer", $time);
                tb.wrap_up();
            end
        end else begin
            repeat (4) @(posedge core_clk);
        end
        #1;
        host_bus = {1'b1, 1'b0, ~rs, ~rw, ~host_bus.data};
    endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the tone transceiver host port.
`timescale 1ns/1ns
module tb
    import ttp_pkg::*;
;
    localparam int unsigned PB = 20;
    logic       core_clk;
    logic       srst;
    logic       clk_en;
    ttp_bus_t   host_bus;
    logic [3:0] host_data_out;
    logic       host_data_oe;
    ttp_rx_t    rx_pins;
    logic       ref_clk;
    logic       pin_out;
    logic       pin_oe;
    logic [4:0] row_seg;
    logic [4:0] col_seg;
    logic       row_on;
    logic       col_on;
    wire        irq_line = pin_oe ? pin_out : 1'b1;
    logic [7:0] exp_q[$];
    logic [7:0] e;
    logic       oe_prev;
    logic [3:0] code;
    logic [4:0] seg_hold;
    int         failures;
    int         cmp_count;
    int         on_cnt;
    int         run_len;
    int         n;

    ttp_host_port #(.P_BURST_CYCLES(PB)) ttp_host_port_i (
        .core_clk                  (core_clk),
        .srst                      (srst),
        .clk_en                    (clk_en),
        .host_bus                  (host_bus),
        .host_data_out             (host_data_out),
        .host_data_oe              (host_data_oe),
        .rx_pins                   (rx_pins),
        .clock_input_pin           (ref_clk),
        .interrupt_or_tone_pin_out (pin_out),
        .interrupt_or_tone_pin_oe  (pin_oe),
        .row_seg                   (row_seg),
        .col_seg                   (col_seg),
        .row_on                    (row_on),
        .col_on                    (col_on)
    );

    ttp_host_model ttp_host_model_i (
        .core_clk     (core_clk),
        .host_bus     (host_bus),
        .host_data_oe (host_data_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        ref_clk = 1'b0;
        forever #140 ref_clk = ~ref_clk;
    end

    // Length of the last unbroken stretch of row tone, in cycles.
    always @(posedge core_clk) begin
        if (row_on === 1'b1) begin
            on_cnt <= on_cnt + 1;
        end else if (on_cnt != 0) begin
            run_len <= on_cnt;
            on_cnt <= 0;
        end
    end

    // Each new read answer is matched against the oldest expectation.
    always @(posedge core_clk) begin
        #2;
        if (host_data_oe === 1'b1 && oe_prev !== 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("ERROR %0t unexpected read answer", $time);
            end else begin
                e = exp_q.pop_front();
                cmp_count++;
                if ((host_data_out & e[7:4]) !== (e[3:0] & e[7:4])) begin
                    failures++;
                    $display("ERROR %0t read %h expected %h", $time, host_data_out, e[3:0]);
                end
            end
        end
        oe_prev = host_data_oe;
    end

    task automatic wrap_up();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic rd(input logic rs, input logic [3:0] m, input logic [3:0] v);
        exp_q.push_back({m, v});
        ttp_host_model_i.access(rs, RW_READ, 4'h0);
    endtask

    task automatic wr(input logic rs, input logic [3:0] d);
        ttp_host_model_i.access(rs, RW_WRITE, d);
    endtask

    task automatic set_rx(input logic st, input logic cp, input logic [3:0] c);
        @(posedge core_clk);
        #1;
        rx_pins = {st, cp, c};
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t level %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_near(input int got, input int exp, input int tol);
        cmp_count++;
        if (got < exp - tol || got > exp + tol) begin
            failures++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    // Waits for row tone (0), interrupt line (1) or column tone (2) to reach v.
    task automatic wait_sig(input int s, input logic v, input int lim);
        n = 0;
        while ((s == 0 ? row_on : s == 1 ? irq_line : col_on) !== v) begin
            if (n == lim) begin
                failures++;
                $display("ERROR %0t wait ran out", $time);
                wrap_up();
            end
            @(posedge core_clk);
            #2;
            n++;
        end
    endtask

    // Cycles between two successive segment steps of one tone.
    task automatic seg_gap(input logic col);
        logic [4:0] s;
        for (int k = 0; k < 2; k++) begin
            s = col ? col_seg : row_seg;
            n = 0;
            while ((col ? col_seg : row_seg) === s && n < 1000) begin
                @(posedge core_clk);
                #2;
                n++;
            end
            if (n == 1000) begin
                failures++;
                $display("ERROR %0t segment step never came", $time);
                wrap_up();
            end
        end
    endtask

    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        rx_pins = '0;
        oe_prev = 1'b0;
        on_cnt = 0;
        run_len = 0;
        failures = 0;
        cmp_count = 0;
        void'($urandom(32'h4636));
        repeat (3) @(posedge core_clk);
        #1;
        srst = 1'b0;
        rd(1'b1, 4'h0, 4'h0);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
        rd(1'b1, 4'h7, 4'h0);
        wr(1'b1, 4'h4);
        code = 4'($urandom);
        set_rx(1'b1, 1'b0, code);
        wait_sig(1, 1'b0, 20);
        rd(1'b0, 4'hf, code);
        rd(1'b1, 4'h7, 4'h5);
        wait_sig(1, 1'b1, 20);
        set_rx(1'b0, 1'b0, ~code);
        wr(1'b0, ~code);
        rd(1'b0, 4'hf, code);
        wait_sig(1, 1'b0, 3 * PB);
        rd(1'b1, 4'h7, 4'h3);
        for (int m = 0; m < 2; m++) begin
            wr(1'b1, m ? 4'h7 : 4'h5);
            wr(1'b0, 4'h1);
            wait_sig(0, 1'b1, 10);
            wait_sig(0, 1'b0, 4 * PB);
            if (m == 0) begin
                wait_sig(1, 1'b0, 3 * PB);
                chk_near(n, PB, 2);
            end else begin
                repeat (2 * PB + 4) @(posedge core_clk);
            end
            chk_near(run_len, PB * (m + 1), 1);
            rd(1'b1, 4'h7, 4'h3);
        end
        set_rx(1'b1, 1'b1, ~code);
        wait_sig(1, 1'b0, 20);
        set_rx(1'b0, 1'b0, ~code);
        wait_sig(1, 1'b1, 20);
        rd(1'b0, 4'hf, code);
        wr(1'b1, 4'hd);
        wr(1'b1, 4'h5);
        wr(1'b0, 4'h1);
        wait_sig(0, 1'b1, 20);
        chk_bit(col_on, 1'b0);
        set_rx(1'b1, 1'b0, code);
        wait_sig(1, 1'b0, 20);
        rd(1'b1, 4'h4, 4'h4);
        set_rx(1'b0, 1'b0, code);
        wr(1'b1, 4'h1);
        seg_gap(1'b0);
        chk_near(n, int'(ROW_DIV[0]) * 28 / 10, 3);
        chk_bit(col_on, 1'b0);
        chk_bit(row_on, 1'b1);
        wr(1'b1, 4'h9);
        wr(1'b1, 4'h1);
        wait_sig(2, 1'b1, 20);
        seg_gap(1'b1);
        chk_near(n, int'(COL_DIV[0]) * 28 / 10, 3);
        @(posedge core_clk);
        #1;
        clk_en = 1'b0;
        seg_hold = col_seg;
        repeat (300) @(posedge core_clk);
        #1;
        chk_bit(col_seg === seg_hold, 1'b1);
        clk_en = 1'b1;
        wr(1'b1, 4'h9);
        wr(1'b1, 4'hf);
        wait_sig(0, 1'b0, 20);
        chk_bit(col_on, 1'b1);
        set_rx(1'b1, 1'b0, code);
        wait_sig(1, 1'b0, 20);
        set_rx(1'b0, 1'b0, code);
        wait_sig(1, 1'b1, 20);
        wrap_up();
    end
endmodule
